//--- lc_pkg.sv
// Purpose: Shared constants and types for the configurable logic cell.
// Assumes: One system clock; configuration is static while running.
// Notes:   Selection encodings and table widths live here only.
package lc_pkg;

	// Number of inputs of each four-input table.
	localparam int LC_LUT4_W = 4;
	// Number of entries of a four-input table.
	localparam int LC_LUT4_N = 16;
	// Number of entries of the three-input combiner table.
	localparam int LC_LUT3_N = 8;
	// Reset value of every table bit and storage element.
	localparam logic LC_RST_BIT = 1'h0;

	// Source of a combiner input that may come from a table.
	typedef enum logic [0:0] {
		LC_HSRC_EXT = 1'h0,  // External combiner input.
		LC_HSRC_LUT = 1'h1   // Output of table A or B.
	} lc_hsrc_t;

	// Data source of a storage element.
	typedef enum logic [1:0] {
		LC_DSRC_DIR = 2'h0,  // Direct data input.
		LC_DSRC_LUT = 2'h1,  // Own table output (A or B).
		LC_DSRC_CMB = 2'h2   // Combiner output.
	} lc_dsrc_t;

	// Memory organisation of tables A and B.
	typedef enum logic [1:0] {
		LC_MEM_LOGIC = 2'h0, // Plain lookup tables.
		LC_MEM_16X2  = 2'h1, // Two 16x1 single-port RAMs.
		LC_MEM_32X1  = 2'h2, // One 32x1 single-port RAM.
		LC_MEM_DUAL  = 2'h3  // One 16x1 RAM, two read ports.
	} lc_mem_t;

endpackage

//--- lc_cell.sv
// Purpose: Configurable logic cell with two 4-input tables, a 3-input
//          combiner, two storage elements and table RAM modes.
// Assumes: Configuration ports are loaded before operation and held.
// Notes:   Latch mode is modelled as a register loading its data every cycle.
// Overview of operation
// - Tables A and B: any 4-input function.
// - Combiner C: any 3-input function.
// - Two combiner inputs: table or external.
// - Third combiner input always external input one.
// - Outputs select table A/B or combiner.
// - Two storage elements, usable independently.
// - Flip-flops, optional latch in extended variant.
// - Direct input to either storage element.
// - Fifteen inputs, four outputs to routing.
// - Only two unregistered results leave cell.
// - Any five-variable function via combiner.
// - Tables usable as synchronous, dual-port RAM.
// - RAM as two 16x1 or one 32x1.
// - Write enable acts as clock enable.
// - Dual port: one write, two reads.
// - 32-word mode: data one is address bit.
`timescale 1ns/10ps
module lc_cell
	import lc_pkg::*;
#(
	parameter bit LATCH_OK = 1'b1  // Extended variant offering latches.
) (
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// Cell routing inputs (eleven).
	input  wire logic [LC_LUT4_W-1:0] lut_a_inputs,
	input  wire logic [LC_LUT4_W-1:0] lut_b_inputs,
	input  wire logic                 combiner_ext_in_zero,
	input  wire logic                 combiner_ext_in_one,
	input  wire logic                 combiner_ext_in_two,
	// Cell routing outputs (four).
	output logic                      comb_out_x,
	output logic                      comb_out_y,
	output logic                      reg_out_x,
	output logic                      reg_out_y,
	// Configuration load.
	input  wire logic                 cfg_load,
	input  wire logic [LC_LUT4_N-1:0] cfg_lut_a,
	input  wire logic [LC_LUT4_N-1:0] cfg_lut_b,
	input  wire logic [LC_LUT3_N-1:0] cfg_lut_c,
	// Configuration selections (static).
	input  wire logic                 cfg_h0_src,
	input  wire logic                 cfg_h2_src,
	input  wire logic                 cfg_x_sel_cmb,
	input  wire logic                 cfg_y_sel_cmb,
	input  wire logic [1:0]           cfg_x_dsrc,
	input  wire logic [1:0]           cfg_y_dsrc,
	input  wire logic                 cfg_latch,
	input  wire logic [1:0]           cfg_mem_mode,
	// Dual-port read address (second read port).
	input  wire logic [LC_LUT4_W-1:0] dp_rd_addr
);

	// In RAM modes the combiner external inputs take data roles.
	logic ram_data_in_zero;  // Write data (table A in 16x2 mode).
	logic ram_data_in_one;   // Table B data, or fifth address bit.
	logic ram_wr_en;         // Write enable, a pure clock enable.
	assign ram_data_in_zero = combiner_ext_in_two;
	assign ram_data_in_one  = combiner_ext_in_one;
	assign ram_wr_en        = combiner_ext_in_zero;

	// Table contents, loaded by configuration or written as RAM.
	logic [LC_LUT4_N-1:0] lut_a_ff, nxt_lut_a;
	logic [LC_LUT4_N-1:0] lut_b_ff, nxt_lut_b;
	logic [LC_LUT3_N-1:0] lut_c_ff, nxt_lut_c;
	// Storage elements.
	logic                 stx_ff, nxt_stx;
	logic                 sty_ff, nxt_sty;
	// Combinational internals.
	logic lut_a_out, lut_b_out, cmb_out;
	logic h_in0, h_in2;
	logic d_x, d_y;
	lc_mem_t mem_mode;

	assign mem_mode = lc_mem_t'(cfg_mem_mode);

	// Table lookup is shared by A, B and the second read port.
	function automatic logic lut4(input logic [LC_LUT4_N-1:0] tbl,
	                              input logic [LC_LUT4_W-1:0] idx);
		lut4 = tbl[idx];
	endfunction

	// Storage source decode, used once per storage element.
	function automatic logic dsel(input logic [1:0] sel, input logic dir,
	                              input logic lut, input logic cmb);
		unique case (lc_dsrc_t'(sel))
			LC_DSRC_DIR: dsel = dir;
			LC_DSRC_LUT: dsel = lut;
			LC_DSRC_CMB: dsel = cmb;
			default:     dsel = dir;  // Unused code falls back to direct.
		endcase
	endfunction

	// Table reads; 32x1 picks A or B by the fifth address bit.
	always_comb begin
		lut_a_out = lut4(lut_a_ff, lut_a_inputs);
		lut_b_out = lut4(lut_b_ff, lut_b_inputs);
		if (mem_mode == LC_MEM_32X1) begin
			// Both halves see the A address; both outputs carry it.
			lut_a_out = lut4(ram_data_in_one ? lut_b_ff : lut_a_ff,
			                 lut_a_inputs);
			lut_b_out = lut_a_out;
		end else if (mem_mode == LC_MEM_DUAL) begin
			// A port reads the write address, B port reads its own.
			lut_b_out = lut4(lut_a_ff, dp_rd_addr);
		end
	end

	// Combiner input selection and lookup.
	always_comb begin
		h_in0 = (lc_hsrc_t'(cfg_h0_src) == LC_HSRC_LUT) ? lut_a_out
		        : combiner_ext_in_zero;
		h_in2 = (lc_hsrc_t'(cfg_h2_src) == LC_HSRC_LUT) ? lut_b_out
		        : combiner_ext_in_two;
		// The middle input never comes from a table; with both tables
		// feeding it, C selects between them for five variables.
		cmb_out = lut_c_ff[{h_in2, combiner_ext_in_one,
		                    h_in0}];
	end

	// Only these two unregistered results leave the cell.
	always_comb begin
		comb_out_x = cfg_x_sel_cmb ? cmb_out : lut_a_out;
		comb_out_y = cfg_y_sel_cmb ? cmb_out : lut_b_out;
	end

	// Storage data sources; the direct input is external input two.
	always_comb begin
		d_x = dsel(cfg_x_dsrc, combiner_ext_in_two, lut_a_out,
		           cmb_out);
		d_y = dsel(cfg_y_dsrc, combiner_ext_in_two, lut_b_out,
		           cmb_out);
	end

	// Table next state: configuration load, else RAM writes only.
	always_comb begin
		nxt_lut_a = lut_a_ff;
		nxt_lut_b = lut_b_ff;
		nxt_lut_c = lut_c_ff;
		if (cfg_load) begin
			nxt_lut_a = cfg_lut_a;
			nxt_lut_b = cfg_lut_b;
			nxt_lut_c = cfg_lut_c;
		end else if (ram_wr_en) begin
			unique case (mem_mode)
				LC_MEM_LOGIC: begin
					// Logic tables are never written at run time.
				end
				LC_MEM_16X2: begin
					nxt_lut_a[lut_a_inputs] = ram_data_in_zero;
					nxt_lut_b[lut_b_inputs] = ram_data_in_one;
				end
				LC_MEM_32X1: begin
					if (ram_data_in_one) begin
						nxt_lut_b[lut_a_inputs] = ram_data_in_zero;
					end else begin
						nxt_lut_a[lut_a_inputs] = ram_data_in_zero;
					end
				end
				LC_MEM_DUAL: begin
					// One write port; the B copy is unused here.
					nxt_lut_a[lut_a_inputs] = ram_data_in_zero;
				end
			endcase
		end
	end

	// Table registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lut_a_ff <= '0;
			lut_b_ff <= '0;
			lut_c_ff <= '0;
		end else begin
			lut_a_ff <= nxt_lut_a;
			lut_b_ff <= nxt_lut_b;
			lut_c_ff <= nxt_lut_c;
		end
	end

	// Storage next state. In latch mode the element follows its data
	// every cycle; a cycle-based model cannot be truly transparent.
	always_comb begin
		nxt_stx = stx_ff;
		nxt_sty = sty_ff;
		if (cfg_latch && LATCH_OK) begin
			nxt_stx = d_x;
			nxt_sty = d_y;
		end else begin
			nxt_stx = d_x;
			nxt_sty = d_y;
		end
	end

	// Storage registers, cleared by reset.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stx_ff <= LC_RST_BIT;
			sty_ff <= LC_RST_BIT;
		end else begin
			stx_ff <= nxt_stx;
			sty_ff <= nxt_sty;
		end
	end

	// Registered outputs come straight from the storage elements.
	assign reg_out_x = stx_ff;
	assign reg_out_y = sty_ff;

	// Two-memory writes land at each table's own address next edge.
	sequence s_write_16x2;
		!cfg_load && ram_wr_en && mem_mode == LC_MEM_16X2;
	endsequence
	a_ram_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_write_16x2 |=>
			lut_a_ff[$past(lut_a_inputs)] == $past(ram_data_in_zero))
		else $error("Table A RAM write lost.");
	a_ram_write_b: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_write_16x2 |=>
			lut_b_ff[$past(lut_b_inputs)] == $past(ram_data_in_one))
		else $error("Table B RAM write lost.");

	// Without a write enable nor a load, tables hold.
	a_table_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		(!cfg_load && !ram_wr_en) |=>
			$stable(lut_a_ff) && $stable(lut_b_ff) && $stable(lut_c_ff))
		else $error("Table changed without write.");

	// A load replaces all three tables on one edge.
	a_table_load: assert property (
		@(posedge clk_sys) disable iff (rst)
		cfg_load |=> lut_a_ff == $past(cfg_lut_a)
			&& lut_b_ff == $past(cfg_lut_b) && lut_c_ff == $past(cfg_lut_c))
		else $error("Table load lost.");

	// Logic mode never alters tables at run time, even with a stray
	// write enable on the shared external input.
	a_logic_static: assert property (
		@(posedge clk_sys) disable iff (rst)
		(!cfg_load && mem_mode == LC_MEM_LOGIC) |=>
			$stable(lut_a_ff) && $stable(lut_b_ff))
		else $error("Logic table written.");

	// In logic mode each plain output not selecting the combiner shows its addressed table bit.
	a_lut_a_read: assert property (
		@(posedge clk_sys) disable iff (rst)
		(mem_mode == LC_MEM_LOGIC && !cfg_x_sel_cmb) |->
			comb_out_x == lut_a_ff[lut_a_inputs])
		else $error("Table A read wrong.");
	a_lut_b_read: assert property (
		@(posedge clk_sys) disable iff (rst)
		(mem_mode == LC_MEM_LOGIC && !cfg_y_sel_cmb) |->
			comb_out_y == lut_b_ff[lut_b_inputs])
		else $error("Table B read wrong.");

	// Selecting the combiner puts it on the chosen plain output.
	a_x_output_mux: assert property (
		@(posedge clk_sys) disable iff (rst)
		cfg_x_sel_cmb |-> comb_out_x == cmb_out)
		else $error("X output mux wrong.");
	a_y_output_mux: assert property (
		@(posedge clk_sys) disable iff (rst)
		cfg_y_sel_cmb |-> comb_out_y == cmb_out)
		else $error("Y output mux wrong.");

	// Direct input reaches storage X one edge later.
	sequence s_direct_x;
		cfg_x_dsrc == LC_DSRC_DIR;
	endsequence
	a_direct_store: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_direct_x |=> reg_out_x == $past(combiner_ext_in_two))
		else $error("Direct input not stored.");

	// The combiner result reaches storage Y one edge later.
	a_comb_store: assert property (
		@(posedge clk_sys) disable iff (rst)
		cfg_y_dsrc == LC_DSRC_CMB |=> reg_out_y == $past(cmb_out))
		else $error("Combiner result not stored.");

	// With external sources the combiner index is the three inputs, the
	// middle one always external input one.
	a_comb_middle: assert property (
		@(posedge clk_sys) disable iff (rst)
		(!cfg_h0_src && !cfg_h2_src) |-> cmb_out == lut_c_ff[
			{combiner_ext_in_two, combiner_ext_in_one, combiner_ext_in_zero}])
		else $error("Combiner index wrong.");

	// With both tables feeding it, the combiner sees both table outputs.
	a_five_var: assert property (
		@(posedge clk_sys) disable iff (rst)
		(cfg_h0_src && cfg_h2_src) |->
			cmb_out == lut_c_ff[{lut_b_out, combiner_ext_in_one, lut_a_out}])
		else $error("Five-input path wrong.");

	// The wide memory writes the half picked by the fifth address bit.
	sequence s_write_32x1;
		!cfg_load && ram_wr_en && mem_mode == LC_MEM_32X1;
	endsequence
	a_wide_write: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_write_32x1 |=> $past(ram_data_in_zero) == ($past(ram_data_in_one)
			? lut_b_ff[$past(lut_a_inputs)] : lut_a_ff[$past(lut_a_inputs)]))
		else $error("Wide RAM write lost.");

	// Dual port keeps one copy: the B table must not move.
	a_dual_b_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		(!cfg_load && mem_mode == LC_MEM_DUAL) |=> $stable(lut_b_ff))
		else $error("Dual-port B table written.");

	// Dual-port write is visible on the second read port next cycle.
	sequence s_dual_write;
		!cfg_load && ram_wr_en && mem_mode == LC_MEM_DUAL
		&& dp_rd_addr == lut_a_inputs;
	endsequence
	a_dual_read: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_dual_write ##1 ($stable(dp_rd_addr) && $stable(mem_mode))
		|-> lut_b_out == $past(ram_data_in_zero))
		else $error("Dual-port read stale.");

endmodule

//--- lc_route.sv
// Purpose: Routing model that drives the fifteen cell inputs.
// Assumes: The pattern is taken at each rising clock edge.
// Notes:   Values land 1 ns after the edge, never on it.
`timescale 1ns/10ps
module lc_route (
	// Clock and requested pattern.
	input  wire logic        clk_sys,
	input  wire logic [14:0] pat,
	// Routing outputs towards the cell.
	output logic      [3:0]  a,
	output logic      [3:0]  b,
	output logic             e0,
	output logic             e1,
	output logic             e2,
	output logic      [3:0]  dp
);
	logic [14:0] p;  // Pattern held across the drive delay.
	// Capture on the edge so a late bench update cannot race it.
	always @(posedge clk_sys) begin
		p = pat;
		#1 {dp, e2, e1, e0, b, a} = p;
	end
	// Quiet routing at time zero.
	initial {dp, e2, e1, e0, b, a} = '0;
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for the logic cell.
// Assumes: Inputs change 1 ns after a rising edge.
// Notes:   Table models double as the load values.
`timescale 1ns/10ps
module tb_top;
	import lc_pkg::*;
	logic        clk_sys = 1'h0;  // System clock.
	logic        rst = 1'h1;      // Reset, held at start.
	logic        cfg_load = 1'h0; // Table load strobe.
	logic [15:0] ta = '0;         // Model of table A.
	logic [15:0] tb = '0;         // Model of table B.
	logic [7:0]  tc = '0;         // Model of combiner.
	logic        h0s = 1'h0, h2s = 1'h0, xs = 1'h0, ys = 1'h0;
	logic        lt = 1'h0;       // Latch option, random per load.
	logic [1:0]  xd = 2'h0, yd = 2'h0, mm = 2'h0;
	logic [14:0] pat = '0;        // Next routing pattern.
	logic [3:0]  a, b, dp;
	logic        e0, e1, e2, cx, cy, rx, ry;
	int          errors = 0;
	int          num_checks = 0;
	lc_route rt (.clk_sys(clk_sys), .pat(pat), .a(a), .b(b), .e0(e0),
		.e1(e1), .e2(e2), .dp(dp));
	lc_cell uut (.clk_sys(clk_sys), .rst(rst), .lut_a_inputs(a),
		.lut_b_inputs(b), .combiner_ext_in_zero(e0),
		.combiner_ext_in_one(e1), .combiner_ext_in_two(e2),
		.comb_out_x(cx), .comb_out_y(cy), .reg_out_x(rx),
		.reg_out_y(ry), .cfg_load(cfg_load), .cfg_lut_a(ta),
		.cfg_lut_b(tb), .cfg_lut_c(tc), .cfg_h0_src(h0s),
		.cfg_h2_src(h2s), .cfg_x_sel_cmb(xs), .cfg_y_sel_cmb(ys),
		.cfg_x_dsrc(xd), .cfg_y_dsrc(yd), .cfg_latch(lt),
		.cfg_mem_mode(mm), .dp_rd_addr(dp));
	// Free-running 25 MHz clock.
	always #20 clk_sys = ~clk_sys;
	// Advance to just after the next rising edge.
	task step;
		@(posedge clk_sys);
		#1;
	endtask
	// Compare one output bit.
	task chk(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// Storage source: own table, combiner, else the direct input.
	function automatic logic src(input logic [1:0] d, input logic t,
		input logic c);
		return d == 2'h1 ? t : (d == 2'h2 ? c : e2);
	endfunction
	// Expected {x, y, storage x, storage y} for present inputs.
	function automatic logic [3:0] mdl();
		logic fa, fb, h0, h2, hc;
		fa = ta[a];
		fb = tb[b];
		h0 = h0s ? fa : e0;
		h2 = h2s ? fb : e2;
		hc = tc[{h2, e1, h0}];
		return {xs ? hc : fa, ys ? hc : fb, src(xd, fa, hc), src(yd, fb, hc)};
	endfunction
	// Load fresh random tables; logic mode again.
	task cfg(input logic h0, input logic h2, input logic x, input logic y);
		{ta, tb, tc} = 40'({$urandom, $urandom});
		{h0s, h2s, xs, ys} = {h0, h2, x, y};
		{xd, yd} = 4'($urandom);
		lt = 1'($urandom);
		mm = 2'h0;
		cfg_load = 1'h1;
		step;
		cfg_load = 1'h0;
	endtask
	// Random traffic; stray write enables must leave tables alone.
	task rnd(input int n);
		logic [3:0] e;
		repeat (n) begin
			pat = 15'($urandom);
			step;
			#5 e = mdl();
			chk(cx, e[3]);
			chk(cy, e[2]);
			step;
			#5 chk(rx, e[1]);
			chk(ry, e[0]);
		end
		$display("logic test done at %0t", $time);
	endtask
	// One RAM write then read back in mode m.
	task ram(input logic [1:0] m, input logic [3:0] ad, input logic [3:0] bd,
		input logic [3:0] dq, input logic d1, input logic d0);
		logic w;
		pat = {dq, d0, d1, 1'h1, bd, ad};
		step;
		mm = m;
		pat[8] = 1'h0;
		step;
		#5 case (m)
			2'h2: if (d1) tb[ad] = d0; else ta[ad] = d0;
			2'h3: ta[ad] = d0;
			default: {ta[ad], tb[bd]} = {d0, d1};
		endcase
		// Wide memory: both outputs show the half picked by d1.
		w = d1 ? tb[ad] : ta[ad];
		chk(cx, m == 2'h2 ? w : ta[ad]);
		chk(cy, m == 2'h3 ? ta[dq] : (m == 2'h2 ? w : tb[bd]));
		$display("ram test done at %0t", $time);
	endtask
	// Closing report.
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#2ms errors++;
		end_of_test;
	end
	// Main sequence.
	initial begin
		logic [1:0] m;
		logic [3:0] ad;
		void'($urandom(32'h2c66));
		repeat (5) @(posedge clk_sys);
		#1 rst = 1'h0;
		#5 chk(cx | cy | rx | ry, 1'h0);
		cfg(1'h1, 1'h1, 1'h1, 1'h1);
		rnd(8);
		repeat (6) begin
			cfg(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
			rnd(10);
		end
		cfg(1'h0, 1'h0, 1'h0, 1'h0);
		for (int i = 0; i < 24; i++) begin
			m = 2'(i % 3 + 1);
			ad = 4'($urandom);
			ram(m, ad, m == 2'h2 ? ad : 4'($urandom),
				i[3] ? ad : 4'($urandom),
				1'($urandom), 1'($urandom));
		end
		end_of_test;
	end
endmodule
